//--- design/holdover_dac_tracking_control.v
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "holdover_consts.vh"

module holdover_dac_tracking_control (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // register port
    input  wire [8:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    // first loop
    input  wire        digital_lock_flag,
    input  wire        pd_valid,
    input  wire [9:0]  tune_code,
    // loss of signal sources
    input  wire [2:0]  internal_los,
    input  wire        input_select_pin0,
    input  wire        input_select_pin1,
    input  wire        status_pin1,
    // clock switch controls
    output reg  [1:0]  selected_input,
    output reg         holdover_active,
    output reg  [9:0]  dac_code,
    output reg         pump_tristate,
    output reg         dynamic_delay_enable,
    output reg         switch_event,
    output wire        irq
);

    // ============================================================
    // state codes
    localparam ST_NORMAL = 1'b0;
    localparam ST_HOLD   = 1'b1;

    // ============================================================
    // configuration and status registers
    reg  [7:0]  low_trip_reg;
    reg  [7:0]  mult_trip_reg;
    reg  [7:0]  rate_cnt_reg;
    reg  [7:0]  switch_ctl_reg;
    reg  [7:0]  exit_hi_reg;
    reg  [7:0]  exit_lo_reg;
    reg  [7:0]  aux_ctl_reg;
    reg  [7:0]  irq_stat_reg;
    reg  [7:0]  irq_en_reg;
    reg  [7:0]  irq_stat_next;
    reg  [7:0]  irq_set;
    reg  [7:0]  irq_clr;
    reg         state_reg;
    reg         state_next;
    reg         lock_d_reg;
    reg         rail_d_reg;
    reg  [13:0] exit_cnt_reg;
    reg  [7:0]  tri_cnt_reg;
    reg  [1:0]  sel_next;
    reg  [7:0]  rd_value;

    wire        tick;
    wire [2:0]  los_vec;
    wire        cur_los;
    wire        upper_hit;
    wire        lower_hit;
    wire        rail_hit;
    wire        rail_event;
    wire        lock_event;
    wire        sw_event;
    wire        forced;
    wire [1:0]  man_sel;
    wire [13:0] exit_count;
    wire        exit_done;
    wire        hold_exit;

    // ============================================================
    // helpers
    // trip span of code n is (n+1) steps of full scale / 64
    function [10:0] trip_span;
        input [5:0] n;
        begin
            trip_span = ({5'h00, n} + 11'h001) << `TRIP_SHIFT;
        end
    endfunction

    // loss flag of one input; code 3 never selected
    function pick_los;
        input [2:0] v;
        input [1:0] s;
        begin
            case (s)
                2'h0:    pick_los = v[0];
                2'h1:    pick_los = v[1];
                default: pick_los = v[2];
            endcase
        end
    endfunction

    // ============================================================
    // tracking update rate
    // multiplier code decoded inside the tick divider
    tracking_rate_tick #(
        .CNT_W      (22)
    ) u_rate (
        .clk        (clk),
        .reset      (reset),
        .mult_code  (mult_trip_reg[`MULT_HI:`MULT_LO]),
        .rate_count (rate_cnt_reg),
        .tick       (tick)
    );

    // ============================================================
    // loss status source
    // pins replace internal detectors
    assign los_vec = switch_ctl_reg[`BIT_EXT_LOS] ?
                     {status_pin1, input_select_pin1, input_select_pin0} : internal_los;
    assign cur_los = pick_los(los_vec, selected_input);

    // ============================================================
    // rail detection on the tuning level
    // upper level counted down from the top
    assign upper_hit = {1'b0, tune_code} >= (`FULL_SCALE - trip_span(mult_trip_reg[`TRIP_HI:0]));
    // lower level counted up from ground
    assign lower_hit = {1'b0, tune_code} <= trip_span(low_trip_reg[`TRIP_HI:0]);
    // gated by rail detect enable, edge only
    assign rail_hit   = switch_ctl_reg[`BIT_RAIL_DET] & (upper_hit | lower_hit);
    assign rail_event = rail_hit & ~rail_d_reg;

    // ============================================================
    // switch events
    // falling edge of loop lock
    assign lock_event = switch_ctl_reg[`BIT_LOCK_SW] & lock_d_reg & ~digital_lock_flag;
    assign sw_event   = lock_event | rail_event;

    assign forced  = aux_ctl_reg[`BIT_MAN_EN] & switch_ctl_reg[`BIT_FORCE];
    assign man_sel = (aux_ctl_reg[`MAN_HI:`MAN_LO] == 2'h3) ? 2'h2 : aux_ctl_reg[`MAN_HI:`MAN_LO];

    // ============================================================
    // holdover exit conditions
    assign exit_count = {exit_hi_reg[5:0], exit_lo_reg};
    assign exit_done  = exit_cnt_reg >= exit_count;
    // exit policy chooses loss status or lock detect
    assign hold_exit  = switch_ctl_reg[`BIT_EXIT_POL] ? (digital_lock_flag & exit_done) : ~cur_los;

    // next holdover state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                if (sw_event && switch_ctl_reg[`BIT_HOLD_EN]) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!switch_ctl_reg[`BIT_HOLD_EN] || hold_exit) begin
                    state_next = ST_NORMAL;
                end
            end
            default: state_next = ST_NORMAL;
        endcase
    end

    // next selected input: forced choice, else rotate on each event
    always @* begin
        sel_next = selected_input;
        if (forced) begin
            sel_next = man_sel;
        end else if (sw_event) begin
            sel_next = (selected_input >= 2'h2) ? 2'h0 : selected_input + 2'h1;
        end
    end

    // ============================================================
    // holdover state, input selection and event pulse
    always @(posedge clk) begin
        if (reset) begin
            state_reg            <= ST_NORMAL;
            holdover_active      <= 1'b0;
            selected_input       <= 2'h0;
            switch_event         <= 1'b0;
            lock_d_reg           <= 1'b0;
            rail_d_reg           <= 1'b0;
            dynamic_delay_enable <= 1'b1;
        end else begin
            state_reg            <= state_next;
            holdover_active      <= (state_next == ST_HOLD);
            selected_input       <= sel_next;
            switch_event         <= sw_event;
            lock_d_reg           <= digital_lock_flag;
            rail_d_reg           <= rail_hit;
            dynamic_delay_enable <= ~forced;
        end
    end

    // ============================================================
    // valid detector clock count for lock based exit
    always @(posedge clk) begin
        if (reset) begin
            exit_cnt_reg <= 14'h0000;
        end else if (state_reg != ST_HOLD || !digital_lock_flag) begin
            exit_cnt_reg <= 14'h0000;   // any lock drop restarts the count
        end else if (pd_valid && !exit_done) begin
            // count valid clocks up to the limit
            exit_cnt_reg <= exit_cnt_reg + 14'h0001;
        end
    end

    // ============================================================
    // charge pump tri-state window after each switch
    always @(posedge clk) begin
        if (reset) begin
            tri_cnt_reg   <= 8'h00;
            pump_tristate <= 1'b0;
        end else begin
            if (sw_event) begin
                tri_cnt_reg <= `SWITCH_TRI_CYC;
            end else if (tri_cnt_reg != 8'h00) begin
                tri_cnt_reg <= tri_cnt_reg - 8'h01;
            end
            pump_tristate <= switch_ctl_reg[`BIT_PUMP_TRI] & (sw_event | (tri_cnt_reg > 8'h01));
        end
    end

    // ============================================================
    // tracked DAC value, held frozen during holdover
    always @(posedge clk) begin
        if (reset) begin
            dac_code <= `RST_DAC_CODE;
        end else if (tick && aux_ctl_reg[`BIT_TRACK_EN] && digital_lock_flag && state_reg == ST_NORMAL) begin
            if (tune_code > dac_code) begin
                dac_code <= dac_code + 10'h001;
            end else if (tune_code < dac_code) begin
                dac_code <= dac_code - 10'h001;
            end
        end
    end

    // ============================================================
    // interrupt status: set wins over clear
    always @* begin
        irq_set = 8'h00;
        irq_set[`IRQ_SWITCH]   = sw_event;
        irq_set[`IRQ_HOLD_IN]  = (state_reg == ST_NORMAL) && (state_next == ST_HOLD);
        irq_set[`IRQ_HOLD_OUT] = (state_reg == ST_HOLD) && (state_next == ST_NORMAL);
        irq_set[`IRQ_RAIL]     = rail_event;
        irq_clr = (wr && addr == `ADDR_IRQ_CLR) ? (wdata & `MASK_IRQ) : 8'h00;
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // ============================================================
    // register writes
    always @(posedge clk) begin
        if (reset) begin
            low_trip_reg   <= `RST_LOW_TRIP;
            mult_trip_reg  <= `RST_MULT_TRIP;
            rate_cnt_reg   <= `RST_RATE_CNT;
            switch_ctl_reg <= `RST_SWITCH_CTL;
            exit_hi_reg    <= `RST_EXIT_HI;
            exit_lo_reg    <= `RST_EXIT_LO;
            aux_ctl_reg    <= `RST_AUX_CTL;
            irq_en_reg     <= 8'h00;
            irq_stat_reg   <= 8'h00;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr) begin
                case (addr)
                    `ADDR_LOW_TRIP:   low_trip_reg   <= wdata & `MASK_TRIP;
                    `ADDR_MULT_TRIP:  mult_trip_reg  <= wdata;
                    `ADDR_RATE_CNT:   rate_cnt_reg   <= wdata;
                    `ADDR_SWITCH_CTL: switch_ctl_reg <= wdata & `MASK_SWITCH_CTL;
                    `ADDR_EXIT_HI:    exit_hi_reg    <= wdata & `MASK_TRIP;
                    `ADDR_EXIT_LO:    exit_lo_reg    <= wdata;
                    `ADDR_AUX_CTL:    aux_ctl_reg    <= wdata & `MASK_AUX_CTL;
                    `ADDR_IRQ_EN:     irq_en_reg     <= wdata & `MASK_IRQ;
                    default: ;
                endcase
            end
        end
    end

    // ============================================================
    // read mux; unmapped and write-only addresses read zero
    always @* begin
        case (addr)
            `ADDR_LOW_TRIP:   rd_value = low_trip_reg;
            `ADDR_MULT_TRIP:  rd_value = mult_trip_reg;
            `ADDR_RATE_CNT:   rd_value = rate_cnt_reg;
            `ADDR_SWITCH_CTL: rd_value = switch_ctl_reg;
            `ADDR_EXIT_HI:    rd_value = exit_hi_reg;
            `ADDR_EXIT_LO:    rd_value = exit_lo_reg;
            `ADDR_AUX_CTL:    rd_value = aux_ctl_reg;
            `ADDR_IRQ_STAT:   rd_value = irq_stat_reg;
            `ADDR_IRQ_EN:     rd_value = irq_en_reg;
            `ADDR_DAC_HI:     rd_value = {6'h00, dac_code[9:8]};
            `ADDR_DAC_LO:     rd_value = dac_code[7:0];
            `ADDR_STATE:      rd_value = {4'h0, cur_los, selected_input, holdover_active};
            default:          rd_value = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rd_value : 8'h00;
        end
    end

endmodule // holdover_dac_tracking_control

//--- design/holdover_consts.vh
`ifndef HOLDOVER_CONSTS_VH
`define HOLDOVER_CONSTS_VH

// ============================================================
// register offsets
`define ADDR_LOW_TRIP    9'h14d
`define ADDR_MULT_TRIP   9'h14e
`define ADDR_RATE_CNT    9'h14f
`define ADDR_SWITCH_CTL  9'h150
`define ADDR_EXIT_HI     9'h151
`define ADDR_EXIT_LO     9'h152
`define ADDR_AUX_CTL     9'h160
`define ADDR_IRQ_STAT    9'h161
`define ADDR_IRQ_CLR     9'h162
`define ADDR_IRQ_EN      9'h163
`define ADDR_DAC_HI      9'h164
`define ADDR_DAC_LO      9'h165
`define ADDR_STATE       9'h166

// ============================================================
// reset values
`define RST_LOW_TRIP     8'h00
`define RST_MULT_TRIP    8'h00
`define RST_RATE_CNT     8'h7f
`define RST_SWITCH_CTL   8'h00
`define RST_EXIT_HI      8'h02
`define RST_EXIT_LO      8'h00
`define RST_AUX_CTL      8'h00
`define RST_DAC_CODE     10'h200

// ============================================================
// write masks, reserved bits stay zero
`define MASK_TRIP        8'h3f
`define MASK_SWITCH_CTL  8'h7f
`define MASK_AUX_CTL     8'h0f
`define MASK_IRQ         8'h0f

// ============================================================
// field positions
`define MULT_HI          7
`define MULT_LO          6
`define TRIP_HI          5
`define BIT_FORCE        6
`define BIT_EXIT_POL     5
`define BIT_LOCK_SW      4
`define BIT_EXT_LOS      3
`define BIT_RAIL_DET     2
`define BIT_PUMP_TRI     1
`define BIT_HOLD_EN      0
`define BIT_TRACK_EN     0
`define BIT_MAN_EN       1
`define MAN_HI           3
`define MAN_LO           2
`define IRQ_SWITCH       0
`define IRQ_HOLD_IN      1
`define IRQ_HOLD_OUT     2
`define IRQ_RAIL         3

// ============================================================
// scale and timing
`define FULL_SCALE       11'h400
`define TRIP_SHIFT       4
`define SWITCH_TRI_CYC   8'h10

`endif

//--- design/tracking_rate_tick.v
`timescale 1ns/100ps
`include "holdover_consts.vh"

// ============================================================
// tracking update tick: one pulse every multiplier*count cycles
module tracking_rate_tick #(
    parameter CNT_W = 22
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // rate settings
    input  wire [1:0]       mult_code,
    input  wire [7:0]       rate_count,
    // update pulse
    output reg              tick
);

    reg  [CNT_W-1:0] cnt_reg;
    wire [CNT_W-1:0] limit;

    // multiplier 4, 64, 1024, 16384 is 4 shifted by 4 per code
    function [CNT_W-1:0] mult_value;
        input [1:0] code;
        begin
            mult_value = {{(CNT_W-3){1'b0}}, 3'h4} << {code, 2'h0};
        end
    endfunction

    assign limit = mult_value(mult_code) * {{(CNT_W-8){1'b0}}, rate_count};

    // a count of zero stalls tracking rather than ticking every cycle
    always @(posedge clk) begin
        if (reset) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick    <= 1'b0;
        end else if (limit == {CNT_W{1'b0}}) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick    <= 1'b0;
        end else if (cnt_reg + 1'b1 >= limit) begin
            cnt_reg <= {CNT_W{1'b0}};   // >= also recovers after shrinking the period
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
        end
    end

endmodule // tracking_rate_tick

//--- tb/ref_sources.sv
`timescale 1ns/100ps
// ============================================================
// reference inputs and first loop as the block sees them
module ref_sources (
    // clock
    input  wire       clk,
    // settings from the bench
    input  wire       lock_set,
    input  wire [2:0] los_set,
    input  wire [2:0] pin_set,
    input  wire [9:0] tune_set,
    // toward the block
    output wire       digital_lock_flag,
    output reg        pd_valid,
    output wire [9:0] tune_code,
    output wire [2:0] internal_los,
    output wire       input_select_pin0,
    output wire       input_select_pin1,
    output wire       status_pin1
);
    reg [1:0] div_reg = 2'h0;
    initial pd_valid = 1'b0;
    // one detector clock in four, none while unlocked
    always @(posedge clk) begin
        div_reg  <= div_reg + 2'h1;
        pd_valid <= lock_set && (div_reg == 2'h3);
    end
    // levels pass straight through
    assign digital_lock_flag = lock_set;
    assign tune_code         = tune_set;
    assign internal_los      = los_set;
    assign {status_pin1, input_select_pin1, input_select_pin0} = pin_set;
endmodule // ref_sources

//--- tb/holdover_dac_tracking_control_properties.sv
`timescale 1ns/100ps
// ============================================================
// port checker for the holdover control block
module holdover_dac_tracking_control_properties (
    // clock and reset
    input wire       clk,
    input wire       reset,
    // register port
    input wire [8:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    // loop and controls
    input wire       digital_lock_flag,
    input wire       holdover_active,
    input wire [9:0] dac_code,
    input wire       pump_tristate,
    input wire       dynamic_delay_enable,
    input wire       switch_event
);
    reg  [7:0] ctl_reg;
    reg  [3:0] aux_reg;
    reg  [4:0] tri_reg;
    wire       forced = ctl_reg[6] && aux_reg[1];
    // shadow copies of written controls, needed since registers are hidden
    always @(posedge clk) begin
        if (reset) begin
            ctl_reg <= 8'h00;
            aux_reg <= 4'h0;
        end else if (wr && addr == 9'h150) begin
            ctl_reg <= wdata;
        end else if (wr && addr == 9'h160) begin
            aux_reg <= wdata[3:0];
        end
    end
    // length of the current tri-state stretch
    always @(posedge clk) begin
        if (reset || !pump_tristate)
            tri_reg <= 5'h00;
        else
            tri_reg <= tri_reg + 5'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence lock_drop_s;
        $past(digital_lock_flag) && !digital_lock_flag && ctl_reg[4];
    endsequence
    sequence event_s;
        ##[1:2] switch_event;
    endsequence
    a_lock_drop_event:
    assert property (lock_drop_s |-> event_s) else $error("no switch event after lock drop");
    a_event_single:
    assert property (switch_event |=> !switch_event) else $error("switch event longer than one cycle");
    a_hold_needs_en:
    assert property ($rose(holdover_active) |-> $past(ctl_reg[0])) else $error("holdover while disabled");
    a_pump_tri_gate:
    assert property ($rose(pump_tristate) |-> $past(ctl_reg[1])) else $error("tri-state while disabled");
    a_pump_tri_len:
    assert property ($fell(pump_tristate) |-> tri_reg == 5'h10) else $error("tri-state window length");
    a_read_idle:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside read slot");
    a_reserved_zero:
    assert property ($past(rd) && $past(addr) == 9'h150 |-> !rdata[7]) else $error("reserved bit set");
    a_force_no_delay:
    assert property (forced && $past(forced) |-> !dynamic_delay_enable) else $error("delay on when forced");
    a_dac_unit_step:
    assert property ($changed(dac_code) |-> dac_code == $past(dac_code) + 10'h001 ||
                     dac_code == $past(dac_code) - 10'h001) else $error("tracking step not one code");
endmodule // holdover_dac_tracking_control_properties

bind holdover_dac_tracking_control holdover_dac_tracking_control_properties u_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .digital_lock_flag(digital_lock_flag), .holdover_active(holdover_active), .dac_code(dac_code),
    .pump_tristate(pump_tristate), .dynamic_delay_enable(dynamic_delay_enable),
    .switch_event(switch_event));

//--- tb/holdover_dac_tracking_control_test.sv
`timescale 1ns/100ps
// ============================================================
// bench for the holdover control block
module holdover_dac_tracking_control_test;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       lock_set = 1'b1;
    logic [2:0] los_set = 3'h0;
    logic [2:0] pin_set = 3'h0;
    logic [9:0] tune_set = 10'h200;
    wire  [7:0] rdata;
    wire  [9:0] tune_code, dac_code;
    wire  [2:0] internal_los;
    wire  [1:0] selected_input;
    wire        digital_lock_flag, pd_valid, input_select_pin0, input_select_pin1, status_pin1;
    wire        holdover_active, pump_tristate, dynamic_delay_enable, switch_event, irq;
    int         mismatches = 0;
    int         num_checks = 0;
    int         cyc = 0;
    // ============================================================
    // block and reference inputs
    holdover_dac_tracking_control dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .digital_lock_flag(digital_lock_flag), .pd_valid(pd_valid), .tune_code(tune_code),
        .internal_los(internal_los), .input_select_pin0(input_select_pin0),
        .input_select_pin1(input_select_pin1), .status_pin1(status_pin1),
        .selected_input(selected_input), .holdover_active(holdover_active), .dac_code(dac_code),
        .pump_tristate(pump_tristate), .dynamic_delay_enable(dynamic_delay_enable),
        .switch_event(switch_event), .irq(irq));
    ref_sources src (
        .clk(clk), .lock_set(lock_set), .los_set(los_set), .pin_set(pin_set), .tune_set(tune_set),
        .digital_lock_flag(digital_lock_flag), .pd_valid(pd_valid), .tune_code(tune_code),
        .internal_los(internal_los), .input_select_pin0(input_select_pin0),
        .input_select_pin1(input_select_pin1), .status_pin1(status_pin1));
    always #5 clk = ~clk;
    // the slowest tracking interval dominates, so the ceiling sits well above it
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            mismatches++;
            test_done();
        end
    end
    // ============================================================
    // shared tasks
    task test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk("rdata", {8'h00, rdata}, {8'h00, exp});
    endtask
    task set_lock(input logic v);
        @(posedge clk);
        lock_set <= v;
    endtask
    task set_tune(input logic [9:0] v);
        @(posedge clk);
        tune_set <= v;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // look for a switch event pulse within n cycles
    task wait_evt(input logic exp, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1 seen = seen | (switch_event === 1'b1);
        end
        chk("switch_event", {15'h0, seen}, {15'h0, exp});
    endtask
    task wait_hold(input logic exp, input int n);
        #1;
        for (int i = 0; i < n && holdover_active !== exp; i++)
            settle(1);
        chk("holdover_active", {15'h0, holdover_active}, {15'h0, exp});
    endtask
    // cycles between two dac steps, after two steps to let new settings land
    task meas(input int exp);
        int         n;
        logic [9:0] prev;
        repeat (3) begin
            prev = dac_code;
            n = 0;
            while (dac_code === prev && n < 40000) begin
                @(posedge clk);
                #1 n++;
            end
        end
        chk("interval", n[15:0], exp[15:0]);
    endtask
    // ============================================================
    // scenarios
    task t_reset();
        rd_chk(9'h14e, 8'h00);
        rd_chk(9'h14f, 8'h7f);
        rd_chk(9'h150, 8'h00);
        rd_chk(9'h1ff, 8'h00);
        chk("dac_code", {6'h00, dac_code}, 16'h0200);
        $display("test reset done");
    endtask
    task t_regs();
        wr_reg(9'h14e, 8'hff);
        wr_reg(9'h14f, 8'h5a);
        rd_chk(9'h14e, 8'hff);
        rd_chk(9'h14f, 8'h5a);
        wr_reg(9'h14e, 8'h00);
        wr_reg(9'h150, 8'hff);
        rd_chk(9'h150, 8'h7f);
        wr_reg(9'h150, 8'h00);
        $display("test registers done");
    endtask
    task t_lock();
        wr_reg(9'h150, 8'h13);
        los_set <= 3'h7;
        set_lock(1'b0);
        wait_evt(1'b1, 3);
        chk("holdover", {15'h0, holdover_active}, 16'h1);
        chk("selected", {14'h0, selected_input}, 16'h1);
        chk("tristate", {15'h0, pump_tristate}, 16'h1);
        chk("irq masked", {15'h0, irq}, 16'h0);
        wr_reg(9'h163, 8'h01);
        #1 chk("irq", {15'h0, irq}, 16'h1);
        rd_chk(9'h161, 8'h03);
        wr_reg(9'h162, 8'h0f);
        #1 chk("irq cleared", {15'h0, irq}, 16'h0);
        @(posedge clk) los_set <= 3'h0;
        set_lock(1'b1);
        wait_hold(1'b0, 4);
        settle(20);
        wr_reg(9'h150, 8'h10);
        set_lock(1'b0);
        wait_evt(1'b1, 3);
        chk("holdover off", {15'h0, holdover_active}, 16'h0);
        set_lock(1'b1);
        wr_reg(9'h150, 8'h01);
        set_lock(1'b0);
        wait_evt(1'b0, 4);
        set_lock(1'b1);
        $display("test lock loss done");
    endtask
    task t_exit();
        wr_reg(9'h151, 8'h00);
        wr_reg(9'h152, 8'h03);
        wr_reg(9'h150, 8'h31);
        set_lock(1'b0);
        wait_evt(1'b1, 3);
        set_lock(1'b1);
        settle(3);
        chk("holdover kept", {15'h0, holdover_active}, 16'h1);
        wait_hold(1'b0, 40);
        wr_reg(9'h150, 8'h19);
        pin_set <= 3'h7;
        set_lock(1'b0);
        wait_evt(1'b1, 3);
        settle(4);
        chk("pin loss", {15'h0, holdover_active}, 16'h1);
        @(posedge clk) pin_set <= 3'h0;
        set_lock(1'b1);
        wait_hold(1'b0, 5);
        $display("test holdover exit done");
    endtask
    task t_rail();
        wr_reg(9'h14e, 8'h03);
        wr_reg(9'h150, 8'h05);
        set_tune(10'd959);
        wait_evt(1'b0, 4);
        set_tune(10'd960);
        wait_evt(1'b1, 3);
        set_tune(10'd17);
        wait_evt(1'b0, 4);
        set_tune(10'd16);
        wait_evt(1'b1, 3);
        set_tune(10'h200);
        wr_reg(9'h150, 8'h01);
        set_tune(10'h3ff);
        wait_evt(1'b0, 4);
        set_tune(10'h200);
        wr_reg(9'h150, 8'h00);
        wr_reg(9'h14e, 8'h00);
        $display("test rail detect done");
    endtask
    task t_force();
        wr_reg(9'h160, 8'h0a);
        // force select set for distribution use
        wr_reg(9'h150, 8'h50);
        settle(2);
        chk("forced input", {14'h0, selected_input}, 16'h2);
        chk("dyn delay", {15'h0, dynamic_delay_enable}, 16'h0);
        wr_reg(9'h160, 8'h06);
        settle(2);
        chk("forced input", {14'h0, selected_input}, 16'h1);
        set_lock(1'b0);
        wait_evt(1'b1, 3);
        chk("no rotation", {14'h0, selected_input}, 16'h1);
        set_lock(1'b1);
        wr_reg(9'h150, 8'h00);
        wr_reg(9'h160, 8'h00);
        $display("test forced input done");
    endtask
    task t_track();
        logic [9:0] held;
        set_tune(10'h3ff);
        wr_reg(9'h160, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr_reg(9'h14e, {m[1:0], 6'h00});
            wr_reg(9'h14f, 8'h01);
            meas(4 << (4 * m));
        end
        wr_reg(9'h14e, 8'h00);
        wr_reg(9'h14f, 8'h02);
        meas(8);
        set_lock(1'b0);
        settle(2);
        held = dac_code;
        settle(40);
        chk("unlocked dac", {6'h00, dac_code}, {6'h00, held});
        set_lock(1'b1);
        wr_reg(9'h14f, 8'h00);
        settle(10);
        held = dac_code;
        settle(40);
        chk("count zero dac", {6'h00, dac_code}, {6'h00, held});
        $display("test tracking done");
    endtask
    // ============================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_lock();
        t_exit();
        t_rail();
        t_force();
        t_track();
        test_done();
    end
endmodule // holdover_dac_tracking_control_test
